// file: hw/pfwe_flash_ctrl.sv
// Top of the flash write and erase controller with its AXI4-Lite register slave.
// Contract
// - Programming only clears bits to zero.
// - Erase leaves every byte reading 0xff.
// - Write and erase timed fully in hardware.
// - Busy flag is one during operations.
// - Stall only fetches missing prefetch and cache.
// - Cached handlers served when code runs cached.
// - Other interrupts wait, then priority order.
// - Redirect set sends data writes to flash.
// - Hardware never clears the redirect bit.
// - Data reads always go to external RAM.
// - Code reads return flash contents.
// - Bank select maps upper code window.
// - Separate 256-byte scratch flash area exists.
// - Erase needs gate, redirect, erase enable set.
// - Erase granularity is one page: 1024 bytes in main flash, 128 bytes in scratch flash.
// - Block mode gathers four or two bytes.
// - Code block programs after address ending 11.
`timescale 1ns/10ps
`include "pfwe_defines.svh"
module pfwe_flash_ctrl #(
  parameter int ADDR_W       = 8,
  parameter int IRQ_N        = 8,
  parameter int ERASE_CYCLES = `PFWE_ERASE_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output pfwe_pkg::pfwe_resp_t     bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output pfwe_pkg::pfwe_resp_t     rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                dataWrValid,
  input  wire logic [15:0]         dataWrAddr,
  input  wire logic [7:0]          dataWrData,
  input  wire logic                dataRdValid,
  input  wire logic [15:0]         dataRdAddr,
  input  wire logic                codeRdValid,
  input  wire logic [15:0]         codeRdAddr,
  input  wire logic                codeRdHit,
  input  wire logic                codeFromCache,
  input  wire logic [IRQ_N-1:0]    irqReq,
  input  wire logic [IRQ_N-1:0]    irqCached,
  output logic                     xramWrValid,
  output logic [15:0]              xramWrAddr,
  output logic [7:0]               xramWrData,
  output logic                     xramRdValid,
  output logic [15:0]              xramRdAddr,
  output logic [7:0]               codeRdData,
  output logic                     codeRdDone,
  output logic                     coreStall,
  output logic [IRQ_N-1:0]         irqGrant,
  output logic                     flashOpInProgress
);
  import pfwe_pkg::*;

  if (ADDR_W < 4 || IRQ_N < 1 || ERASE_CYCLES < 8) begin : g_chk
    $error("pfwe_flash_ctrl: parameter out of range");
  end

  logic              storeWriteRedirect_ff, eraseEnableBit_ff, scratchSel_ff;
  logic              softwareFlashWriteGate_ff, blockWriteMode_ff;
  logic [1:0]        upperBankSelect_ff;
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  pfwe_resp_t        bresp_ff, rresp_ff;
  logic [31:0]       rdata_ff;
  logic              xramWrValid_ff, xramRdValid_ff, codeRdDone_ff, coreStall_ff;
  logic [15:0]       xramWrAddr_ff, xramRdAddr_ff;
  logic [7:0]        xramWrData_ff;
  logic [31:0]       blkData_ff;
  logic [3:0]        blkMask_ff;
  logic [IRQ_N-1:0]  irqPend_ff, irqGrant_ff;
  logic              busy, opDone;

  // Register bus decode: a write is taken when address and data are both offered.
  wire               wrTake   = awvalid && wvalid && !bvalid_ff && !awready_ff;
  wire               rdTake   = arvalid && !rvalid_ff && !arready_ff;
  wire               wrCtrl   = wrTake && wstrb[0] && (awaddr == ADDR_W'(`PFWE_CTRL_OFS));
  wire               wrBank   = wrTake && wstrb[0] && (awaddr == ADDR_W'(`PFWE_BANK_OFS));
  wire               wrMapped = (awaddr == ADDR_W'(`PFWE_CTRL_OFS))
                             || (awaddr == ADDR_W'(`PFWE_BANK_OFS))
                             || (awaddr == ADDR_W'(`PFWE_STAT_OFS));
  wire               rdCtrl   = (araddr == ADDR_W'(`PFWE_CTRL_OFS));
  wire               rdBank   = (araddr == ADDR_W'(`PFWE_BANK_OFS));
  wire               rdStat   = (araddr == ADDR_W'(`PFWE_STAT_OFS));
  wire [4:0]         ctrlVal  = {blockWriteMode_ff, softwareFlashWriteGate_ff, scratchSel_ff,
                                 eraseEnableBit_ff, storeWriteRedirect_ff};
  wire [31:0]        rdMux    = rdCtrl ? {27'h0000000, ctrlVal}
                              : rdBank ? {26'h0000000, upperBankSelect_ff, 4'h0}
                              : rdStat ? {31'h00000000, busy} : 32'h00000000;

  // Bus handshakes; unmapped offsets answer with a decode error.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= 2'h0;
      rdata_ff   <= 32'h00000000;
    end else if (clkEn) begin
      awready_ff <= wrTake;
      wready_ff  <= wrTake;
      arready_ff <= rdTake;
      if (wrTake) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wrMapped ? 2'h0 : 2'h3;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rdTake) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= (rdCtrl || rdBank || rdStat) ? 2'h0 : 2'h3;
        rdata_ff  <= rdMux;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Control bits change only on software writes, never by hardware.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {blockWriteMode_ff, softwareFlashWriteGate_ff, scratchSel_ff, eraseEnableBit_ff,
       storeWriteRedirect_ff} <= `PFWE_CTRL_RESET;
      upperBankSelect_ff <= `PFWE_BANK_RESET;
    end else if (clkEn) begin
      if (wrCtrl) begin
        storeWriteRedirect_ff     <= wdata[`PFWE_CTRL_REDIRECT];
        eraseEnableBit_ff         <= wdata[`PFWE_CTRL_ERASE];
        scratchSel_ff             <= wdata[`PFWE_CTRL_SCRATCH];
        softwareFlashWriteGate_ff <= wdata[`PFWE_CTRL_GATE];
        blockWriteMode_ff         <= wdata[`PFWE_CTRL_BLOCK];
      end
      if (wrBank) begin
        upperBankSelect_ff <= wdata[`PFWE_BANK_LSB +: 2];
      end
    end
  end

  // Data-space write steering and the flash operation requests.
  wire               toFlash    = dataWrValid && storeWriteRedirect_ff;
  wire               toXram     = dataWrValid && !storeWriteRedirect_ff;
  wire               flashTake  = toFlash && softwareFlashWriteGate_ff && !busy;
  wire               eraseStart = flashTake && eraseEnableBit_ff;
  wire               progReq    = flashTake && !eraseEnableBit_ff;
  wire               wrScratch  = scratchSel_ff && (dataWrAddr[15:8] == `PFWE_SCRATCH_TOP);
  wire               blkLast    = wrScratch ? dataWrAddr[0] : (&dataWrAddr[1:0]);
  wire               progStart  = progReq && (!blockWriteMode_ff || blkLast);
  wire [3:0]         byteSel    = 4'h1 << dataWrAddr[1:0];
  wire [3:0]         progMask   = (blockWriteMode_ff ? blkMask_ff : 4'h0) | byteSel;
  wire [31:0]        progData   = blkData_ff & ~({32{1'b1}} >> 0 & {{8{byteSel[3]}},
                                  {8{byteSel[2]}}, {8{byteSel[1]}}, {8{byteSel[0]}}})
                                | ({24'h000000, dataWrData} << {dataWrAddr[1:0], 3'h0});
  wire [16:0]        wrPhys     = {dataWrAddr[15] ? upperBankSelect_ff : 2'h0,
                                   dataWrAddr[14:0]};
  wire [16:0]        rdPhys     = {codeRdAddr[15] ? upperBankSelect_ff : 2'h0,
                                   codeRdAddr[14:0]};
  wire               rdScratch  = scratchSel_ff && (codeRdAddr[15:8] == `PFWE_SCRATCH_TOP);
  wire               flashRd    = codeRdValid && !codeRdHit && !busy;

  // Gathers the bytes of a block until its last byte launches the program.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blkData_ff <= 32'h00000000;
      blkMask_ff <= 4'h0;
    end else if (clkEn) begin
      if (progStart) begin
        blkMask_ff <= 4'h0;
      end else if (progReq && blockWriteMode_ff) begin
        blkData_ff <= progData;
        blkMask_ff <= progMask;
      end
    end
  end

  pfwe_flash_array u_array (
    .clk       (clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .progEn    (progStart),
    .eraseEn   (eraseStart),
    .opScratch (wrScratch),
    .opAddr    (wrPhys),
    .progData  (progData),
    .progMask  (progMask),
    .rdEn      (flashRd),
    .rdScratch (rdScratch),
    .rdAddr    (rdPhys),
    .rdData_ff (codeRdData)
  );

  pfwe_op_timer #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .WRITE_CYCLES (`PFWE_WRITE_CYCLES)
  ) u_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .clkEn      (clkEn),
    .startWrite (progStart),
    .startErase (eraseStart),
    .busy_ff    (busy),
    .opDone_ff  (opDone)
  );

  // Interrupt selection: while busy only cached handlers with cached code qualify.
  wire               cachedRun = codeFromCache && !coreStall_ff;
  wire [IRQ_N-1:0]   eligible  = busy ? (irqPend_ff & irqCached & {IRQ_N{cachedRun}})
                                      : irqPend_ff;
  wire [IRQ_N-1:0]   grantSel  = eligible & (~eligible + 1'b1);

  // External RAM path, stall flag and pending interrupts; arrivals win over service.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xramWrValid_ff <= 1'b0;
      xramWrAddr_ff  <= 16'h0000;
      xramWrData_ff  <= 8'h00;
      xramRdValid_ff <= 1'b0;
      xramRdAddr_ff  <= 16'h0000;
      codeRdDone_ff  <= 1'b0;
      coreStall_ff   <= 1'b0;
      irqPend_ff     <= '0;
      irqGrant_ff    <= '0;
    end else if (clkEn) begin
      xramWrValid_ff <= toXram;
      xramWrAddr_ff  <= dataWrAddr;
      xramWrData_ff  <= dataWrData;
      xramRdValid_ff <= dataRdValid;
      xramRdAddr_ff  <= dataRdAddr;
      codeRdDone_ff  <= flashRd;
      coreStall_ff   <= busy && codeRdValid && !codeRdHit;
      irqPend_ff     <= (irqPend_ff & ~grantSel) | irqReq;
      irqGrant_ff    <= grantSel;
    end
  end

  assign awready           = awready_ff;
  assign wready            = wready_ff;
  assign bvalid            = bvalid_ff;
  assign bresp             = bresp_ff;
  assign arready           = arready_ff;
  assign rvalid            = rvalid_ff;
  assign rresp             = rresp_ff;
  assign rdata             = rdata_ff;
  assign xramWrValid       = xramWrValid_ff;
  assign xramWrAddr        = xramWrAddr_ff;
  assign xramWrData        = xramWrData_ff;
  assign xramRdValid       = xramRdValid_ff;
  assign xramRdAddr        = xramRdAddr_ff;
  assign codeRdDone        = codeRdDone_ff;
  assign coreStall         = coreStall_ff;
  assign irqGrant          = irqGrant_ff;
  assign flashOpInProgress = busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !clkEn);

  sequence s_erase_req;
    dataWrValid && storeWriteRedirect_ff && softwareFlashWriteGate_ff
      && eraseEnableBit_ff && !busy;
  endsequence
  sequence s_busy_run;
    busy [*8];
  endsequence

  a_erase_holds_busy: assert property (s_erase_req |=> s_busy_run)
    else $error("Erase did not hold busy.");
  a_erase_needs_gates: assert property (eraseStart |-> storeWriteRedirect_ff
    && softwareFlashWriteGate_ff && eraseEnableBit_ff)
    else $error("Erase launched without all enables.");
  a_redirect_sticky: assert property (storeWriteRedirect_ff && !wrCtrl
    |=> storeWriteRedirect_ff)
    else $error("Redirect bit cleared without software.");
  a_data_read_external_data_ram: assert property (dataRdValid |=> xramRdValid
    && xramRdAddr == $past(dataRdAddr))
    else $error("Data read not sent to external RAM.");
  a_write_to_external_data_ram: assert property (dataWrValid && !storeWriteRedirect_ff
    |=> xramWrValid && !$rose(busy))
    else $error("Write with redirect clear missed external RAM.");
  a_stall_cause: assert property (coreStall |-> $past(busy) && $past(codeRdValid)
    && !$past(codeRdHit))
    else $error("Stall without a flash fetch during busy.");
  a_block_commit: assert property (progStart && blockWriteMode_ff && !wrScratch
    |-> dataWrAddr[1:0] == 2'h3)
    else $error("Code block programmed before its last byte.");
  a_irq_busy_hold: assert property (busy && (irqGrant_ff == '0) ##1 (irqGrant != '0) &&
    $past(busy) |-> $past(codeFromCache) && ((irqGrant & ~$past(irqCached)) == '0))
    else $error("Uncached interrupt served during an operation.");
endmodule

// file: hw/pfwe_defines.svh
// Offsets, field positions, reset values and timing counts of the flash write controller.
`ifndef PFWE_DEFINES_SVH
`define PFWE_DEFINES_SVH
`define PFWE_CTRL_OFS      8'h00
`define PFWE_BANK_OFS      8'h04
`define PFWE_STAT_OFS      8'h08
`define PFWE_CTRL_REDIRECT 0
`define PFWE_CTRL_ERASE    1
`define PFWE_CTRL_SCRATCH  2
`define PFWE_CTRL_GATE     3
`define PFWE_CTRL_BLOCK    4
`define PFWE_BANK_LSB      4
`define PFWE_STAT_BUSY     0
`define PFWE_CTRL_RESET    5'h00
`define PFWE_BANK_RESET    2'h1
`define PFWE_CLK_MHZ       25
`define PFWE_ERASE_TIME_US 12000
`define PFWE_WRITE_TIME_US 50
`define PFWE_ERASE_CYCLES  (`PFWE_ERASE_TIME_US * `PFWE_CLK_MHZ)
`define PFWE_WRITE_CYCLES  (`PFWE_WRITE_TIME_US * `PFWE_CLK_MHZ)
`define PFWE_SCRATCH_TOP   8'h00
`endif

// file: hw/pfwe_pkg.sv
// Types shared by the flash write controller modules.
package pfwe_pkg;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} pfwe_op_t;
  typedef logic [1:0] pfwe_resp_t;
endpackage

// file: hw/pfwe_op_timer.sv
// Hardware timer that runs one flash write or erase and raises busy meanwhile.
`timescale 1ns/10ps
module pfwe_op_timer #(
  parameter int CNT_W        = 20,
  parameter int ERASE_CYCLES = 300000,
  parameter int WRITE_CYCLES = 1250
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  input  wire logic startWrite,
  input  wire logic startErase,
  output logic      busy_ff,
  output logic      opDone_ff
);
  import pfwe_pkg::*;

  if (ERASE_CYCLES < 1 || WRITE_CYCLES < 1 || ERASE_CYCLES >= 2**CNT_W
      || WRITE_CYCLES >= 2**CNT_W) begin : g_chk
    $error("pfwe_op_timer: cycle counts do not fit the counter");
  end

  pfwe_op_t           state_ff;
  pfwe_op_t           nxt_state;
  logic [CNT_W-1:0]   cnt_ff;
  logic [CNT_W-1:0]   nxt_cnt;
  logic               nxt_done;

  // Loads the duration at start and counts down to zero without software help.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      OP_IDLE: begin
        if (startErase) begin
          nxt_state = OP_ERASE;
          nxt_cnt   = CNT_W'(ERASE_CYCLES - 1);
        end else if (startWrite) begin
          nxt_state = OP_WRITE;
          nxt_cnt   = CNT_W'(WRITE_CYCLES - 1);
        end
      end
      OP_WRITE, OP_ERASE: begin
        if (cnt_ff == '0) begin
          nxt_state = OP_IDLE;
          nxt_done  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_state = OP_IDLE;
    endcase
  end

  // State, count and busy flag, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= OP_IDLE;
      cnt_ff    <= '0;
      busy_ff   <= 1'b0;
      opDone_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      busy_ff   <= (nxt_state != OP_IDLE);
      opDone_ff <= nxt_done;
    end
  end

  a_done_clears_busy: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
    opDone_ff |-> !busy_ff && $past(busy_ff))
    else $error("Completion pulse without busy dropping.");
endmodule

// file: hw/pfwe_flash_array.sv
// Main code flash and scratch flash storage with AND-only program and page erase.
`timescale 1ns/10ps
module pfwe_flash_array #(
  parameter int MAIN_AW  = 17,
  parameter int PAGE_AW  = 10,
  parameter int SCR_AW   = 8,
  parameter int SPAGE_AW = 7
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               clkEn,
  input  wire logic               progEn,
  input  wire logic               eraseEn,
  input  wire logic               opScratch,
  input  wire logic [MAIN_AW-1:0] opAddr,
  input  wire logic [31:0]        progData,
  input  wire logic [3:0]         progMask,
  input  wire logic               rdEn,
  input  wire logic               rdScratch,
  input  wire logic [MAIN_AW-1:0] rdAddr,
  output logic [7:0]              rdData_ff
);
  if (PAGE_AW >= MAIN_AW || SPAGE_AW >= SCR_AW || SCR_AW > MAIN_AW || SPAGE_AW < 2)
  begin : g_chk
    $error("pfwe_flash_array: address widths are inconsistent");
  end

  logic [7:0] mainMem [2**MAIN_AW];
  logic [7:0] scrMem  [2**SCR_AW];

  // Program clears bits only; erase sets a whole page to ones.
  always_ff @(posedge clk) begin
    if (clkEn && eraseEn) begin
      if (opScratch) begin
        for (int i = 0; i < 2**SPAGE_AW; i++) begin
          scrMem[{opAddr[SCR_AW-1:SPAGE_AW], SPAGE_AW'(i)}] <= 8'hff;
        end
      end else begin
        for (int i = 0; i < 2**PAGE_AW; i++) begin
          mainMem[{opAddr[MAIN_AW-1:PAGE_AW], PAGE_AW'(i)}] <= 8'hff;
        end
      end
    end else if (clkEn && progEn) begin
      for (int k = 0; k < 4; k++) begin
        if (progMask[k] && opScratch) begin
          scrMem[{opAddr[SCR_AW-1:2], 2'(k)}] <=
            scrMem[{opAddr[SCR_AW-1:2], 2'(k)}] & progData[8*k +: 8];
        end else if (progMask[k]) begin
          mainMem[{opAddr[MAIN_AW-1:2], 2'(k)}] <=
            mainMem[{opAddr[MAIN_AW-1:2], 2'(k)}] & progData[8*k +: 8];
        end
      end
    end
  end

  // Registered read port for code-space reads.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_ff <= 8'h00;
    end else if (clkEn && rdEn) begin
      rdData_ff <= rdScratch ? scrMem[rdAddr[SCR_AW-1:0]] : mainMem[rdAddr];
    end
  end
endmodule

// file: test/pfwe_core_model.sv
// Model of the core that issues data writes, data reads and code fetches.
`timescale 1ns/10ps
module pfwe_core_model (
  input  wire logic   clk,
  input  wire logic   busy,
  output logic        dataWrValid,
  output logic [15:0] dataWrAddr,
  output logic [7:0]  dataWrData,
  output logic        dataRdValid,
  output logic [15:0] dataRdAddr,
  output logic        codeRdValid,
  output logic [15:0] codeRdAddr,
  output logic        codeRdHit
);
  // The core starts idle and never hits the cache, so every fetch needs flash.
  initial begin
    dataWrValid = 1'b0;
    dataWrAddr  = 16'h0000;
    dataWrData  = 8'h00;
    dataRdValid = 1'b0;
    dataRdAddr  = 16'h0000;
    codeRdValid = 1'b0;
    codeRdAddr  = 16'h0000;
    codeRdHit   = 1'b0;
  end

  // One write instruction; released lines then show the inverse of the last value.
  task automatic dataWrite(input logic [15:0] a, input logic [7:0] d);
    dataWrAddr  <= a;
    dataWrData  <= d;
    dataWrValid <= 1'b1;
    @(posedge clk);
    dataWrValid <= 1'b0;
    dataWrAddr  <= ~a;
    dataWrData  <= ~d;
    @(posedge clk);
  endtask

  // One data read instruction.
  task automatic dataRead(input logic [15:0] a);
    dataRdAddr  <= a;
    dataRdValid <= 1'b1;
    @(posedge clk);
    dataRdValid <= 1'b0;
    dataRdAddr  <= ~a;
    @(posedge clk);
  endtask

  // A fetch is held while the flash is busy, since the core is stalled then.
  task automatic codeRead(input logic [15:0] a);
    codeRdAddr  <= a;
    codeRdValid <= 1'b1;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    codeRdValid <= 1'b0;
    codeRdAddr  <= ~a;
    @(posedge clk);
  endtask
endmodule

// file: test/program_flash_write_erase_ctrl_tb_top.sv
// Self-checking bench of the flash write and erase controller.
`timescale 1ns/10ps
`define PFWE_CHK(what, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    errTotal++; \
    $display("[FAIL] %s expected %h seen %h", what, e, g); \
  end \
end
module program_flash_write_erase_ctrl_tb_top;
  import pfwe_pkg::*;
  localparam int ECYC = 16;
  localparam int WCYC = 1250;
  logic        clk, reset_n, clkEn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, xramWrValid, xramRdValid;
  logic        codeRdDone, coreStall, flashOpInProgress, codeFromCache;
  logic        dataWrValid, dataRdValid, codeRdValid, codeRdHit;
  logic [7:0]  awaddr, araddr, irqReq, irqCached, irqGrant, xramWrData, codeRdData, d, e;
  logic [7:0]  dataWrData;
  logic [15:0] dataWrAddr, dataRdAddr, codeRdAddr, xramWrAddr, xramRdAddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  pfwe_resp_t  bresp, rresp;
  logic [33:0] notes[$];
  int          errTotal, comparisons;

  pfwe_flash_ctrl #(.ERASE_CYCLES(ECYC)) dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .dataWrValid(dataWrValid), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataRdValid(dataRdValid), .dataRdAddr(dataRdAddr),
    .codeRdValid(codeRdValid), .codeRdAddr(codeRdAddr), .codeRdHit(codeRdHit),
    .codeFromCache(codeFromCache), .irqReq(irqReq), .irqCached(irqCached),
    .xramWrValid(xramWrValid), .xramWrAddr(xramWrAddr), .xramWrData(xramWrData),
    .xramRdValid(xramRdValid), .xramRdAddr(xramRdAddr), .codeRdData(codeRdData),
    .codeRdDone(codeRdDone), .coreStall(coreStall), .irqGrant(irqGrant),
    .flashOpInProgress(flashOpInProgress));

  pfwe_core_model core (.clk(clk), .busy(flashOpInProgress), .dataWrValid(dataWrValid),
    .dataWrAddr(dataWrAddr), .dataWrData(dataWrData), .dataRdValid(dataRdValid),
    .dataRdAddr(dataRdAddr), .codeRdValid(codeRdValid), .codeRdAddr(codeRdAddr),
    .codeRdHit(codeRdHit));

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  // Takes the oldest note off the queue and compares it with what appeared.
  task automatic takeNote(input logic [33:0] got, input string what);
    logic [33:0] ex;
    ex = (notes.size() > 0) ? notes.pop_front() : 'x;
    `PFWE_CHK(what, ex, got)
  endtask

  // Watches every result port and checks each result as it appears.
  always @(posedge clk) begin
    if (rvalid === 1'b1) takeNote({rresp, rdata}, "register read");
    if (bvalid === 1'b1) takeNote({bresp, 32'h00000000}, "write response");
    if (xramWrValid === 1'b1) takeNote({10'h0, xramWrAddr, xramWrData}, "ram write");
    if (xramRdValid === 1'b1) takeNote({18'h0, xramRdAddr}, "ram read");
    if (codeRdDone === 1'b1) takeNote({26'h0, codeRdData}, "code read");
    if (irqGrant !== 8'h00) takeNote({26'h0, irqGrant}, "grant");
  end

  // Register write; bready stays high so the response is taken when it comes.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    notes.push_back({(a inside {8'h00, 8'h04, 8'h08}) ? 2'h0 : 2'h3, 32'h00000000});
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    @(posedge clk);
  endtask

  // Register read with its expected response code and data noted first.
  task automatic axr(input logic [7:0] a, input logic [33:0] ex);
    notes.push_back(ex);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge clk);
  endtask

  // Counts the cycles for which busy stays high.
  task automatic busyLen(input int n);
    int c;
    c = 0;
    while (flashOpInProgress === 1'b1 && c < 3000) begin
      c++;
      @(posedge clk);
    end
    `PFWE_CHK("busy cycles", n, c)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic reportAndStop();
    $display("comparisons %0d errors %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    reportAndStop();
  end

  // Main sequence; the flash starts blank and unknown, as if loaded only through the
  // test port, so every check erases its page first.
  // Bank select moves to two for the window check, clear of the reserved top page.
  initial begin
    clk = 1'b0; reset_n = 1'b0; clkEn = 1'b1; awaddr = 8'h00; awvalid = 1'b0;
    wdata = 32'h0; wstrb = 4'h1; wvalid = 1'b0; bready = 1'b1; araddr = 8'h00;
    arvalid = 1'b0; rready = 1'b1; irqReq = 8'h00; irqCached = 8'h00; codeFromCache = 1'b0;
    void'($urandom(43931));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    axr(8'h00, 34'h0);
    axr(8'h04, 34'h10);
    axr(8'h08, 34'h0);
    axr(8'h0c, {2'b11, 32'h0});
    axw(8'h0c, 32'h0);
    axw(8'h04, 32'h20);
    axr(8'h04, 34'h20);
    d = 8'($urandom);
    notes.push_back({10'h0, 16'h1234, d});
    core.dataWrite(16'h1234, d);
    axw(8'h00, 32'h0b);
    notes.push_back({18'h0, 16'h0005});
    core.dataRead(16'h0005);
    core.dataWrite(16'h83ff, 8'h00);
    busyLen(ECYC);
    notes.push_back(34'hff);
    core.codeRead(16'h8005);
    core.dataWrite(16'h03ff, 8'h00);
    busyLen(ECYC);
    axr(8'h00, 34'h0b);
    notes.push_back(34'hff);
    core.codeRead(16'h0005);
    axw(8'h00, 32'h09);
    d = 8'($urandom);
    core.dataWrite(16'h0005, d);
    busyLen(WCYC);
    notes.push_back({26'h0, d});
    core.codeRead(16'h0005);
    axw(8'h00, 32'h19);
    for (int i = 0; i < 3; i++)
      core.dataWrite(16'h0008 + 16'(i), 8'h10 + 8'(i));
    core.dataWrite(16'h000b, d);
    busyLen(WCYC);
    notes.push_back({26'h0, 8'h11});
    core.codeRead(16'h0009);
    notes.push_back({26'h0, d});
    core.codeRead(16'h000b);
    axw(8'h00, 32'h09);
    e = 8'($urandom);
    core.dataWrite(16'h0005, e);
    axw(8'h00, 32'h08);
    irqReq        <= 8'h0e;
    irqCached     <= 8'h08;
    codeFromCache <= 1'b1;
    notes.push_back(34'h08);
    @(posedge clk);
    irqReq <= 8'h00;
    repeat (2) @(posedge clk);
    irqCached     <= 8'h00;
    codeFromCache <= 1'b0;
    notes.push_back({26'h0, d & e});
    fork
      core.codeRead(16'h0005);
      begin
        repeat (3) @(posedge clk);
        `PFWE_CHK("stall", 1'b1, coreStall)
        while (flashOpInProgress !== 1'b0) @(posedge clk);
        notes.push_back(34'h02);
        notes.push_back(34'h04);
      end
    join
    repeat (8) @(posedge clk);
    `PFWE_CHK("notes left", 0, notes.size())
    reportAndStop();
  end
endmodule
